// ==== ipcb_pkg.sv ====
package ipcb_pkg;
    // Register byte offsets on APB
    localparam logic [11:0] ADDR_CONFIG_ONE = 12'h000;
    localparam logic [11:0] ADDR_CONFIG_TWO = 12'h004;
    localparam logic [11:0] ADDR_CONFIG_THREE = 12'h008;
    localparam int NUM_REGS = 3;
    localparam int NUM_SLOTS = 4;
    localparam int NUM_SRC = 12;
    // Field positions within one byte slot
    localparam int SLOT_WIDTH = 8;
    localparam int PRIO_LSB = 2;
    localparam int PRIO_WIDTH = 3;
    localparam int SUB_LSB = 0;
    localparam int SUB_WIDTH = 2;
    // Implemented bits of a register: five per byte slot
    localparam logic [31:0] IMPL_MASK = 32'h1F1F1F1F;
    localparam logic [31:0] RESET_VALUE = 32'h00000000;
    localparam logic [2:0] PRIO_DISABLED = 3'h0;

    // One source as the arbiter sees it
    typedef struct packed {
        logic [2:0] priority_level;
        logic [1:0] subpriority;
    } ipcb_src_cfg_type;

    typedef enum logic [1:0] {
        IPCB_IDLE = 2'b00,
        IPCB_ACCESS = 2'b01
    } ipcb_apb_state_type;
endpackage

// ==== ipcb_apb_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module ipcb_apb_slave
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    output logic [1:0] reg_index,
    output logic addr_hit,
    output logic wr_take,
    output logic rd_take,
    output ipcb_pkg::ipcb_apb_state_type state_reg
);
    ipcb_pkg::ipcb_apb_state_type state_next;

    // Address decode
    assign addr_hit = (paddr == ipcb_pkg::ADDR_CONFIG_ONE) || (paddr == ipcb_pkg::ADDR_CONFIG_TWO)
        || (paddr == ipcb_pkg::ADDR_CONFIG_THREE);
    assign reg_index = paddr[3:2];
    // Zero-wait slave: transfer completes in its first access cycle
    assign wr_take = psel && penable && pwrite;
    assign rd_take = psel && penable && !pwrite;

    // Phase tracking, informative only
    always_comb
    begin
        case (state_reg)
            ipcb_pkg::IPCB_IDLE: state_next = (psel && !penable) ? ipcb_pkg::IPCB_ACCESS : ipcb_pkg::IPCB_IDLE;
            ipcb_pkg::IPCB_ACCESS: state_next = (psel && !penable) ? ipcb_pkg::IPCB_ACCESS : ipcb_pkg::IPCB_IDLE;
            default: state_next = ipcb_pkg::IPCB_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            state_reg <= ipcb_pkg::IPCB_IDLE;
        else
            state_reg <= state_next;
    end
endmodule
`default_nettype wire

// ==== ipcb_cfg_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
module ipcb_cfg_reg
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] wr_strb,
    output logic [31:0] value_reg
);
    logic [31:0] strb_mask;
    logic [31:0] value_next;

    // Byte lanes, then only implemented bits are stored
    assign strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}}
        & ipcb_pkg::IMPL_MASK;
    assign value_next = (value_reg & ~strb_mask) | (wr_data & strb_mask);

    // Cleared at reset so every source starts disabled
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            value_reg <= ipcb_pkg::RESET_VALUE;
        else if (wr_en)
            value_reg <= value_next;
    end
endmodule
`default_nettype wire

// ==== ipcb_top.sv ====
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ipcb_top
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output ipcb_pkg::ipcb_src_cfg_type [11:0] src_cfg,
    output logic [11:0] src_enabled
);
    logic [1:0] reg_index;
    logic addr_hit;
    logic wr_take;
    logic rd_take;
    ipcb_pkg::ipcb_apb_state_type bus_state;
    logic [31:0] cfg_value [0:2];
    logic [31:0] rd_mux;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    ipcb_pkg::ipcb_src_cfg_type [11:0] src_cfg_next;
    ipcb_pkg::ipcb_src_cfg_type [11:0] src_cfg_reg;
    logic [11:0] enabled_next;
    logic [11:0] enabled_reg;

    ipcb_apb_slave u_slave
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .reg_index(reg_index),
        .addr_hit(addr_hit),
        .wr_take(wr_take),
        .rd_take(rd_take),
        .state_reg(bus_state)
    );

    // One register per group of four sources
    genvar gi;
    generate
        for (gi = 0; gi < ipcb_pkg::NUM_REGS; gi++)
        begin : g_reg
            logic sel;
            assign sel = wr_take && addr_hit && (reg_index == 2'(gi));
            ipcb_cfg_reg u_cfg
            (
                .ref_clk(ref_clk),
                .rst(rst),
                .wr_en(sel),
                .wr_data(pwdata),
                .wr_strb(pstrb),
                .value_reg(cfg_value[gi])
            );
        end
    endgenerate

    // Read mux; reserved bits were never stored, so they read as zero
    assign rd_mux = (!addr_hit) ? 32'h00000000 :
        (reg_index == 2'h0) ? cfg_value[0] :
        (reg_index == 2'h1) ? cfg_value[1] : cfg_value[2];

    // Source k sits in register k/4, slot 3-(k%4): external, output compare, capture, timer
    genvar si;
    generate
        for (si = 0; si < ipcb_pkg::NUM_SRC; si++)
        begin : g_src
            localparam int RI = si / ipcb_pkg::NUM_SLOTS;
            localparam int BASE = (ipcb_pkg::NUM_SLOTS - 1 - (si % ipcb_pkg::NUM_SLOTS)) * ipcb_pkg::SLOT_WIDTH;
            assign src_cfg_next[si].priority_level =
                cfg_value[RI][BASE + ipcb_pkg::PRIO_LSB +: ipcb_pkg::PRIO_WIDTH];
            assign src_cfg_next[si].subpriority =
                cfg_value[RI][BASE + ipcb_pkg::SUB_LSB +: ipcb_pkg::SUB_WIDTH];
            assign enabled_next[si] = (src_cfg_next[si].priority_level != ipcb_pkg::PRIO_DISABLED);
        end
    endgenerate

    // Bus answer registered; ready stands high, zero-wait
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg <= (psel && !penable && !pwrite) ? rd_mux : prdata_reg;
            pslverr_reg <= psel && !penable && !addr_hit; // Unmapped address errors
        end
    end

    // Arbiter view, registered so outputs come from flops
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            src_cfg_reg <= '0;
            enabled_reg <= 12'h000;
        end
        else
        begin
            src_cfg_reg <= src_cfg_next;
            enabled_reg <= enabled_next;
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign pready = 1'b1;
    assign src_cfg = src_cfg_reg;
    assign src_enabled = enabled_reg;
endmodule
`default_nettype wire

// ==== ipcb_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module ipcb_props
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire ipcb_pkg::ipcb_src_cfg_type [11:0] src_cfg,
    input wire logic [11:0] src_enabled
);
    // Access phase decode; the outputs land two edges after the write
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire hit = paddr inside {12'h000, 12'h004, 12'h008};
    logic [11:0] en_exp;
    always_comb
        for (int k = 0; k < 12; k++)
            en_exp[k] = src_cfg[k].priority_level != 3'h0;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    chk_ext_one: assert property
        (wr && paddr == 12'h000 && pstrb[3] |-> ##2 src_cfg[0] == $past(pwdata[28:24], 2)) else $error("ext one");
    chk_tmr_one: assert property
        (wr && paddr == 12'h000 && pstrb[0] |-> ##2 src_cfg[3] == $past(pwdata[4:0], 2)) else $error("timer one");
    chk_cmp_two: assert property
        (wr && paddr == 12'h004 && pstrb[2] |-> ##2 src_cfg[5] == $past(pwdata[20:16], 2)) else $error("cmp two");
    chk_ext_three: assert property
        (wr && paddr == 12'h008 && pstrb[3] |-> ##2 src_cfg[8] == $past(pwdata[28:24], 2)) else $error("ext three");
    chk_cap_three: assert property
        (wr && paddr == 12'h008 && pstrb[1] |-> ##2 src_cfg[10] == $past(pwdata[12:8], 2)) else $error("cap three");
    chk_enable_map: assert property (src_enabled == en_exp) else $error("enable map");
    chk_reset_clear: assert property
        ($fell(rst) |-> src_cfg == '0 && src_enabled == 12'h000) else $error("reset value");
    chk_unmapped_err: assert property
        (acc |-> pslverr == !hit && pready) else $error("error flag");
endmodule
bind ipcb_top ipcb_props u_props (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .src_cfg, .src_enabled);
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hC71298A9;
    logic [3:0] pstrb = 4'h0;
    logic [11:0] src_enabled;
    ipcb_pkg::ipcb_src_cfg_type [11:0] src_cfg;
    logic [31:0] mdl [3] = '{default: 32'h0};
    int fails = 0, total_checks = 0;
    // Free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    ipcb_top uut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .src_cfg, .src_enabled);
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Only strobed lanes change; reserved bits never stick
    function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & ipcb_pkg::IMPL_MASK;
        return (o & ~m) | (d & m);
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Request held until the edge that sees pready; answer taken at that edge, then released
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk_src();
        @(negedge ref_clk);
        for (int k = 0; k < 12; k++)
        begin
            chk({27'h0, src_cfg[k]}, {27'h0, mdl[k / 4][(3 - k % 4) * 8 +: 5]});
            chk({31'h0, src_enabled[k]}, {31'h0, mdl[k / 4][(3 - k % 4) * 8 + 2 +: 3] != 3'h0});
        end
    endtask
    // Write, read back, then compare every source output
    task automatic xfer(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s);
        chk({31'h0, err}, {31'h0, a > 12'h008});
        if (a < 12'h00C)
            mdl[a[3:2]] = merge(mdl[a[3:2]], d, s);
        apb(1'b0, a, 32'h0, 4'h0);
        chk({31'h0, err}, {31'h0, a > 12'h008});
        chk(rd, a < 12'h00C ? mdl[a[3:2]] : 32'h0);
        chk_src();
    endtask
    task automatic finish_test();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        chk_src();
        // Every priority and subpriority code; software keeps reserved bits at zero
        for (int p = 0; p < 8; p++)
            xfer(12'(4 * (p % 3)), {4{3'b000, 3'(p), 2'(p)}}, 4'hF);
        // Random words, lanes and addresses, unmapped word included
        repeat (40)
        begin
            seed = lfsr(seed);
            xfer({8'h0, seed[3:2], 2'b00}, lfsr(seed) & ipcb_pkg::IMPL_MASK, seed[7:4]);
        end
        finish_test();
    end
    // Hang guard, far beyond the expected run
    initial
    begin
        #50000;
        fails++;
        finish_test();
    end
endmodule
`default_nettype wire
